// *** logic/kdn_notify.sv ***
// Keyword detection notifier: pin pulse, counter and HID report paths
// What this block does
// - Each detection pulses every general output whose pin mask bit is set.
// - Pulse length is the programmed period times ten milliseconds.
// - Pin mask and period come from registers or boot configuration.
// - A counter adds one per detection and reads back its value.
// - Host may write the counter; a zero write restarts counting.
// - Pulse, counter and HID paths each have their own enable.
// - HID path sets the mapped report bit, clears it 300 ms later.
// - Three reports exist: keyboard, consumer and telephony.
// - Default mapping is keyboard byte 0 bit 0; bits 4-7 reserved.
// - Boot configuration may remap detection to other report, byte, bit.
// - Detection arrives as a strobe from the pipeline output watcher.
// - Without a loaded model no detection is ever raised.
// - Models up to 250 kB are accepted, only one active.
// - A zero pin mask disables the pulse path.
`timescale 1ns/1ps
module kdn_notify #(
   parameter int TICK_CYCLES = kdn_pkg::PULSE_UNIT_CYC,
   parameter int HID_CYCLES  = kdn_pkg::HID_HOLD_CYC,
   parameter int COUNT_W     = 32
) (
   // Clock and reset
   input  wire logic                 CLOCK,
   input  wire logic                 RST_N,
   // Detector strobe
   input  wire logic                 DETECT_STROBE,
   // Boot configuration
   input  wire logic                 BOOT_VALID,
   input  wire kdn_pkg::kdn_boot_cfg_t BOOT_CFG,
   // Register port
   input  wire logic [7:0]           ADDR,
   input  wire logic [31:0]          WDATA,
   input  wire logic                 WR,
   input  wire logic                 RD,
   output logic [31:0]               RDATA,
   // Notification outputs
   output logic [3:0]                GENERAL_OUTPUT,
   output kdn_pkg::kdn_hid_rpt_t     HID_REPORTS,
   output logic                      IRQ
);

   logic [2:0]                      ctrl_ff;
   logic [3:0]                      pin_mask_ff;
   logic [15:0]                     period_ff;
   logic [COUNT_W-1:0]              count_ff;
   kdn_pkg::kdn_hid_map_t           map_ff;
   logic [8:0]                      model_kb_ff;
   logic                            model_ok_ff;
   logic [kdn_pkg::IRQ_BITS-1:0]    irq_stat_ff;
   logic [kdn_pkg::IRQ_BITS-1:0]    irq_mask_ff;
   logic [3:0]                      gpo_sel_ff;
   logic [3:0]                      gpo_ff;
   kdn_pkg::kdn_hid_map_t           hid_lat_ff;
   kdn_pkg::kdn_hid_rpt_t           rpt_ff;
   logic                            pulse_prev_ff;
   logic [31:0]                     rdata_ff;
   logic                            irq_ff;
   logic                            pulse_active;
   logic                            hid_active;

   // Address decode
   wire wr_ctrl  = WR && (ADDR == kdn_pkg::OFF_CTRL);
   wire wr_mask  = WR && (ADDR == kdn_pkg::OFF_PIN_MASK);
   wire wr_per   = WR && (ADDR == kdn_pkg::OFF_PERIOD);
   wire wr_cnt   = WR && (ADDR == kdn_pkg::OFF_COUNT);
   wire wr_map   = WR && (ADDR == kdn_pkg::OFF_HID_MAP);
   wire wr_model = WR && (ADDR == kdn_pkg::OFF_MODEL);
   wire wr_istat = WR && (ADDR == kdn_pkg::OFF_IRQ_STAT);
   wire wr_imask = WR && (ADDR == kdn_pkg::OFF_IRQ_MASK);

   // Path enables
   wire en_pulse = ctrl_ff[kdn_pkg::CTRL_EN_PULSE];
   wire en_count = ctrl_ff[kdn_pkg::CTRL_EN_COUNT];
   wire en_hid   = ctrl_ff[kdn_pkg::CTRL_EN_HID];

   // Detection gated by a loaded model
   wire det = DETECT_STROBE && model_ok_ff;

   // Path starts; zero mask or zero period never starts a pulse
   wire start_pulse = det && en_pulse && (pin_mask_ff != 4'h0)
                      && (period_ff != 16'h0000);
   wire start_hid   = det && en_hid;

   // Map request from the bus, checked before acceptance
   wire [3:0] req_table  = WDATA[kdn_pkg::MAP_TABLE_LSB +: 4];
   wire [3:0] req_source = WDATA[kdn_pkg::MAP_SOURCE_LSB +: 4];
   // Fields regrouped from register layout into struct order
   wire kdn_pkg::kdn_hid_map_t req_map = {
      WDATA[kdn_pkg::MAP_REPORT_LSB +: 2], WDATA[kdn_pkg::MAP_BYTE_POS],
      WDATA[kdn_pkg::MAP_BIT_LSB +: 3]};
   wire map_req_ok = (req_table == kdn_pkg::DET_MAP_TABLE)
                     && (req_source == kdn_pkg::DET_MAP_SOURCE)
                     && map_legal(req_map);
   wire map_take   = wr_map && map_req_ok;
   wire map_refuse = wr_map && !map_req_ok;

   // Model size check
   wire [8:0] req_kb      = WDATA[8:0];
   wire       model_fits  = (req_kb <= kdn_pkg::MODEL_MAX_KB);
   wire       model_refuse = wr_model && !model_fits;
   wire       boot_fits   = (BOOT_CFG.model_kb <= kdn_pkg::MODEL_MAX_KB);

   // A report bit is legal if a report is named and is not reserved
   function automatic logic map_legal(input kdn_pkg::kdn_hid_map_t m);
      map_legal = (m.report != 2'h0)
                  && !((m.report == kdn_pkg::RPT_KEYBOARD) && !m.byte_sel
                       && (m.bit_sel >= kdn_pkg::KBD_RSVD_FIRST));
   endfunction

   // Interrupt events
   wire pulse_done = pulse_prev_ff && !pulse_active;
   wire [kdn_pkg::IRQ_BITS-1:0] irq_evt = {
      model_refuse, map_refuse, pulse_done, det};

   // Configuration registers; a bus write overrides boot data
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_ff     <= kdn_pkg::CTRL_RESET;
         pin_mask_ff <= kdn_pkg::PIN_MASK_RESET;
         period_ff   <= kdn_pkg::PERIOD_RESET;
         irq_mask_ff <= '0;
      end else begin
         ctrl_ff     <= wr_ctrl ? WDATA[2:0] :
                        BOOT_VALID ? BOOT_CFG.enables : ctrl_ff;
         pin_mask_ff <= wr_mask ? WDATA[3:0] :
                        BOOT_VALID ? BOOT_CFG.pin_mask : pin_mask_ff;
         period_ff   <= wr_per ? WDATA[15:0] :
                        BOOT_VALID ? BOOT_CFG.period : period_ff;
         irq_mask_ff <= wr_imask ? WDATA[kdn_pkg::IRQ_BITS-1:0] : irq_mask_ff;
      end
   end

   // Report mapping, default keyboard byte 0 bit 0
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         map_ff <= '{report: kdn_pkg::RPT_KEYBOARD, byte_sel: 1'b0,
                     bit_sel: 3'h0};
      end else if (map_take) begin
         map_ff <= req_map;
      end else if (BOOT_VALID && map_legal(BOOT_CFG.map)) begin
         map_ff <= BOOT_CFG.map;
      end
   end

   // One model slot; a zero size unloads, oversize is refused
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         model_kb_ff <= '0;
         model_ok_ff <= 1'b0;
      end else if (wr_model && model_fits) begin
         model_kb_ff <= req_kb;
         model_ok_ff <= (req_kb != 9'h000);
      end else if (BOOT_VALID && boot_fits) begin
         model_kb_ff <= BOOT_CFG.model_kb;
         model_ok_ff <= (BOOT_CFG.model_kb != 9'h000);
      end
   end

   // Detection counter; the host write wins so only later hits count
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         count_ff <= '0;
      end else if (wr_cnt) begin
         count_ff <= WDATA[COUNT_W-1:0];
      end else if (det && en_count) begin
         count_ff <= count_ff + COUNT_W'(1);
      end
   end

   // Sticky status; a new event beats a same-cycle clear
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         irq_stat_ff <= '0;
         irq_ff      <= 1'b0;
      end else begin
         irq_stat_ff <= (irq_stat_ff
                         & ~(wr_istat ? WDATA[kdn_pkg::IRQ_BITS-1:0] : '0))
                        | irq_evt;
         irq_ff      <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // Pulse timer in 10 ms units
   kdn_timer #(.PRE(TICK_CYCLES), .UW(16)) u_pulse_tmr (
      .clk    (CLOCK),
      .rst_n  (RST_N),
      .start  (start_pulse),
      .units  (period_ff),
      .active (pulse_active)
   );

   // HID hold timer, one 300 ms unit
   kdn_timer #(.PRE(HID_CYCLES), .UW(1)) u_hid_tmr (
      .clk    (CLOCK),
      .rst_n  (RST_N),
      .start  (start_hid),
      .units  (1'b1),
      .active (hid_active)
   );

   // Mask and map latched at detection so a rewrite cannot glitch outputs
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         gpo_sel_ff    <= '0;
         gpo_ff        <= '0;
         hid_lat_ff    <= '0;
         pulse_prev_ff <= 1'b0;
      end else begin
         gpo_sel_ff    <= start_pulse ? pin_mask_ff : gpo_sel_ff;
         gpo_ff        <= pulse_active ? gpo_sel_ff : 4'h0;
         hid_lat_ff    <= start_hid ? map_ff : hid_lat_ff;
         pulse_prev_ff <= pulse_active;
      end
   end

   // One-hot bit within a report image
   wire [kdn_pkg::HID_RPT_BITS-1:0] hid_bit =
      kdn_pkg::HID_RPT_BITS'(1) << {hid_lat_ff.byte_sel, hid_lat_ff.bit_sel};
   wire [kdn_pkg::HID_RPT_NUM*kdn_pkg::HID_RPT_BITS-1:0] rpt_nxt;

   // Three report images, each driven only when selected
   genvar r;
   generate
      for (r = 0; r < kdn_pkg::HID_RPT_NUM; r++) begin : g_rpt
         assign rpt_nxt[r*kdn_pkg::HID_RPT_BITS +: kdn_pkg::HID_RPT_BITS] =
            (hid_active && (hid_lat_ff.report == 2'(r + 1))) ?
            hid_bit : '0;
      end
   endgenerate

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rpt_ff <= '0;
      end else begin
         rpt_ff <= kdn_pkg::kdn_hid_rpt_t'(rpt_nxt);
      end
   end

   // Read selection; unmapped addresses read zero
   wire [31:0] rd_mux =
      (ADDR == kdn_pkg::OFF_CTRL)     ? {29'h0, ctrl_ff} :
      (ADDR == kdn_pkg::OFF_PIN_MASK) ? {28'h0, pin_mask_ff} :
      (ADDR == kdn_pkg::OFF_PERIOD)   ? {16'h0, period_ff} :
      (ADDR == kdn_pkg::OFF_COUNT)    ? 32'(count_ff) :
      (ADDR == kdn_pkg::OFF_HID_MAP)  ? {16'h0, kdn_pkg::DET_MAP_SOURCE,
                                         kdn_pkg::DET_MAP_TABLE, 2'h0,
                                         map_ff.bit_sel, map_ff.byte_sel,
                                         map_ff.report} :
      (ADDR == kdn_pkg::OFF_MODEL)    ? {22'h0, model_ok_ff, model_kb_ff} :
      (ADDR == kdn_pkg::OFF_IRQ_STAT) ? {28'h0, irq_stat_ff} :
      (ADDR == kdn_pkg::OFF_IRQ_MASK) ? {28'h0, irq_mask_ff} :
      (ADDR == kdn_pkg::OFF_STATE)    ? {30'h0, hid_active, pulse_active} :
      32'h0000_0000;

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= RD ? rd_mux : 32'h0000_0000;
      end
   end

   assign RDATA          = rdata_ff;
   assign GENERAL_OUTPUT = gpo_ff;
   assign HID_REPORTS    = rpt_ff;
   assign IRQ            = irq_ff;

   // Helper counters measuring how long each path stays active
   logic [63:0] pulse_len_ff;
   logic [63:0] hid_len_ff;
   logic [15:0] per_lat_ff;
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         pulse_len_ff <= '0;
         hid_len_ff   <= '0;
         per_lat_ff   <= '0;
      end else begin
         pulse_len_ff <= start_pulse ? 64'h0 :
                         pulse_active ? pulse_len_ff + 64'h1 : pulse_len_ff;
         hid_len_ff   <= start_hid ? 64'h0 :
                         hid_active ? hid_len_ff + 64'h1 : hid_len_ff;
         per_lat_ff   <= start_pulse ? period_ff : per_lat_ff;
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   AST_PULSE_PINS: assert property (
      start_pulse |-> ##2 (GENERAL_OUTPUT == $past(pin_mask_ff, 2)))
      else $error("pulse pins differ from pin mask");
   AST_PULSE_LEN: assert property (
      $fell(pulse_active) |->
         (pulse_len_ff == 64'(per_lat_ff) * 64'(TICK_CYCLES)))
      else $error("pulse length not period times unit");
   AST_MASK_ZERO: assert property (
      (pin_mask_ff == 4'h0 && !pulse_active) |=> !pulse_active)
      else $error("pulse started with zero mask");
   AST_COUNT_INC: assert property (
      (det && en_count && !wr_cnt) |=> (count_ff == $past(count_ff) + 1'b1))
      else $error("counter missed a detection");
   AST_COUNT_WR: assert property (
      wr_cnt |=> (count_ff == $past(WDATA[COUNT_W-1:0])))
      else $error("counter write not taken");
   AST_PATH_EN: assert property (
      (!en_count && !wr_cnt) |=> $stable(count_ff))
      else $error("disabled counter moved");
   AST_PATH_EN_HID: assert property (
      (!en_hid && !hid_active) |=> !hid_active)
      else $error("disabled report path started");
   AST_HID_SET: assert property (
      start_hid |-> ##2 (HID_REPORTS != '0))
      else $error("report bit not set on detection");
   AST_HID_HOLD: assert property (
      $fell(hid_active) |-> (hid_len_ff == 64'(HID_CYCLES)))
      else $error("report bit hold length wrong");
   AST_MAP_GUARD: assert property (
      (wr_map && req_table != kdn_pkg::DET_MAP_TABLE && !BOOT_VALID)
         |=> $stable(map_ff))
      else $error("foreign map table accepted");
   AST_NO_MODEL: assert property (
      !model_ok_ff |-> ##1 !$past(det) && $stable(count_ff) || $past(wr_cnt))
      else $error("detection raised without a model");
   AST_RESTART: assert property (
      (start_pulse && pulse_active) |=> (pulse_active && pulse_len_ff == 0))
      else $error("pulse timer not restarted");

   COV_PULSE: cover property (start_pulse ##[1:20] $fell(pulse_active));
   COV_HID: cover property (start_hid ##2 (HID_REPORTS.keyboard != '0));
   COV_RESTART: cover property (start_pulse && pulse_active);
   COV_IRQ: cover property ($rose(IRQ));

endmodule

// *** logic/kdn_timer.sv ***
// Restartable duration timer counting prescaled units
`timescale 1ns/1ps
module kdn_timer #(
   parameter int PRE = 400000,
   parameter int UW  = 16
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Control
   input  wire logic          start,
   input  wire logic [UW-1:0] units,
   // Status
   output logic               active
);

   logic [31:0]   pre_cnt_ff;
   logic [UW-1:0] unit_cnt_ff;
   logic [UW-1:0] units_ff;
   logic          active_ff;

   // End of one unit and of the whole run
   wire last_pre  = (pre_cnt_ff == 32'(PRE - 1));
   wire last_unit = (unit_cnt_ff == units_ff - UW'(1));

   // A start always reloads, so a repeat detection restarts the run
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_ff  <= '0;
         unit_cnt_ff <= '0;
         units_ff    <= '0;
         active_ff   <= 1'b0;
      end else if (start) begin
         pre_cnt_ff  <= '0;
         unit_cnt_ff <= '0;
         units_ff    <= units;
         active_ff   <= (units != '0);
      end else if (active_ff) begin
         pre_cnt_ff  <= last_pre ? 32'h0000_0000 : pre_cnt_ff + 32'h0000_0001;
         unit_cnt_ff <= last_pre ? unit_cnt_ff + UW'(1) : unit_cnt_ff;
         active_ff   <= !(last_pre && last_unit);
      end
   end

   assign active = active_ff;

endmodule

// *** pkg/kdn_pkg.sv ***
// Shared constants and types for the keyword detection notifier
package kdn_pkg;

   // Register offsets
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_PIN_MASK  = 8'h04;
   localparam logic [7:0] OFF_PERIOD    = 8'h08;
   localparam logic [7:0] OFF_COUNT     = 8'h0C;
   localparam logic [7:0] OFF_HID_MAP   = 8'h10;
   localparam logic [7:0] OFF_MODEL     = 8'h14;
   localparam logic [7:0] OFF_IRQ_STAT  = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK  = 8'h1C;
   localparam logic [7:0] OFF_STATE     = 8'h20;

   // Control field positions and reset value
   localparam int CTRL_EN_PULSE = 0;
   localparam int CTRL_EN_COUNT = 1;
   localparam int CTRL_EN_HID   = 2;
   localparam logic [2:0] CTRL_RESET = 3'h6;

   // Map register field positions
   localparam int MAP_REPORT_LSB = 0;
   localparam int MAP_BYTE_POS   = 2;
   localparam int MAP_BIT_LSB    = 3;
   localparam int MAP_TABLE_LSB  = 8;
   localparam int MAP_SOURCE_LSB = 12;

   // Only the detector's own map table and source are accepted
   localparam logic [3:0] DET_MAP_TABLE  = 4'h2;
   localparam logic [3:0] DET_MAP_SOURCE = 4'h0;

   // Report selectors
   localparam logic [1:0] RPT_KEYBOARD  = 2'h1;
   localparam logic [1:0] RPT_CONSUMER  = 2'h2;
   localparam logic [1:0] RPT_TELEPHONY = 2'h3;
   localparam int HID_RPT_NUM  = 3;
   localparam int HID_RPT_BITS = 16;
   // Keyboard byte 0 bits 4 and up are reserved
   localparam logic [2:0] KBD_RSVD_FIRST = 3'h4;

   // Interrupt status bit positions
   localparam int IRQ_DETECT     = 0;
   localparam int IRQ_PULSE_DONE = 1;
   localparam int IRQ_MAP_REJECT = 2;
   localparam int IRQ_MODEL_REJ  = 3;
   localparam int IRQ_BITS       = 4;

   // Model size limit in kilobytes
   localparam logic [8:0] MODEL_MAX_KB = 9'h0FA;

   // Reset values of the pulse path
   localparam logic [3:0]  PIN_MASK_RESET = 4'h0;
   localparam logic [15:0] PERIOD_RESET   = 16'h000A;

   // Timing
   localparam int CLK_PERIOD_NS  = 25;
   localparam int PULSE_UNIT_MS  = 10;
   localparam int HID_HOLD_MS    = 300;
   localparam int PULSE_UNIT_CYC = PULSE_UNIT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int HID_HOLD_CYC   = HID_HOLD_MS * 1000000 / CLK_PERIOD_NS;

   // Report bit selection
   typedef struct packed {
      logic [1:0] report;
      logic       byte_sel;
      logic [2:0] bit_sel;
   } kdn_hid_map_t;

   // Three report images driven to the HID endpoint
   typedef struct packed {
      logic [HID_RPT_BITS-1:0] telephony;
      logic [HID_RPT_BITS-1:0] consumer;
      logic [HID_RPT_BITS-1:0] keyboard;
   } kdn_hid_rpt_t;

   // Settings delivered once from the boot configuration store
   typedef struct packed {
      logic [2:0]   enables;
      logic [3:0]   pin_mask;
      logic [15:0]  period;
      kdn_hid_map_t map;
      logic [8:0]   model_kb;
   } kdn_boot_cfg_t;

endpackage

// *** verification/kdn_host_model.sv ***
// Host-side partner: reset driver and observer of the pin and HID report outputs
`timescale 1ns/1ps
module kdn_host_model (
   // Clock and restart request
   input  wire logic                  clk,
   input  wire logic                  restart,
   // Device outputs watched
   input  wire logic [3:0]            pins,
   input  wire kdn_pkg::kdn_hid_rpt_t hid,
   // Reset into the device
   output logic                       rst_n,
   // Last pulse seen on each path
   output logic [3:0]                 pin_seen,
   output logic [15:0]                pin_len,
   output logic [47:0]                hid_seen,
   output logic [15:0]                hid_len,
   output logic [7:0]                 falls
);
   logic [15:0] pin_run;
   logic [15:0] hid_run;

   // Falls on both paths in one cycle must both be counted
   wire pin_fall = (pins == 4'h0) && (pin_run != 16'h0000);
   wire hid_fall = (hid == 48'h0000_0000_0000) && (hid_run != 16'h0000);

   // Reset held eight cycles at start and on each restart request
   initial begin
      rst_n = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      forever begin
         @(posedge clk);
         if (restart) begin
            rst_n <= 1'b0;
            repeat (8) @(posedge clk);
            rst_n <= 1'b1;
         end
      end
   end

   // Widths counted while high, latched when the output drops
   always @(posedge clk) begin
      if (!rst_n) begin
         {pin_seen, pin_len, hid_seen, hid_len, falls} <= '0;
         {pin_run, hid_run} <= '0;
      end else begin
         if (pins != 4'h0) begin
            pin_run <= pin_run + 16'h0001;
            pin_seen <= pins;
         end else if (pin_fall) begin
            pin_len <= pin_run;
            pin_run <= 16'h0000;
         end
         if (!hid_fall && hid_run != 16'h0000 || hid != '0) begin
            hid_run <= hid_run + 16'h0001;
            hid_seen <= hid;
         end else if (hid_fall) begin
            hid_len <= hid_run;
            hid_run <= 16'h0000;
         end
         falls <= falls + 8'(pin_fall) + 8'(hid_fall);
      end
   end
endmodule

// *** verification/kdn_notify_bench.sv ***
// Self-checking bench for the keyword detection notifier
`timescale 1ns/1ps
module kdn_notify_bench;
   localparam int TICK = 4;
   localparam int HOLD = 10;
   logic                   clock = 1'b0;
   logic                   strobe = 1'b0;
   logic                   boot_valid = 1'b0;
   logic                   wr = 1'b0;
   logic                   rd = 1'b0;
   logic                   restart = 1'b0;
   logic [7:0]             addr = 8'h00;
   logic [31:0]            wdata = 32'h0000_0000;
   kdn_pkg::kdn_boot_cfg_t boot_cfg = '0;
   logic                   rst_n;
   logic [31:0]            rdata;
   logic [3:0]             gen_out;
   kdn_pkg::kdn_hid_rpt_t  hid;
   logic                   irq;
   logic [3:0]             pin_seen;
   logic [15:0]            pin_len;
   logic [47:0]            hid_seen;
   logic [15:0]            hid_len;
   logic [7:0]             falls;
   logic [7:0]             nf = 8'h00;
   int                     num_errors = 0;
   int                     samples_checked = 0;
   logic [7:0]  offs [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                              8'h18, 8'h1C, 8'h20, 8'h24};
   logic [31:0] rv [10] = '{{29'h0, kdn_pkg::CTRL_RESET},
                            {28'h0, kdn_pkg::PIN_MASK_RESET},
                            {16'h0, kdn_pkg::PERIOD_RESET}, 32'h0000_0000,
                            32'h0000_0201, '0, '0, '0, '0, '0};

   // Clock at 40 MHz
   always #12.5 clock = ~clock;

   kdn_notify #(.TICK_CYCLES(TICK), .HID_CYCLES(HOLD), .COUNT_W(32)) DUT (
      .CLOCK(clock), .RST_N(rst_n), .DETECT_STROBE(strobe),
      .BOOT_VALID(boot_valid), .BOOT_CFG(boot_cfg), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .GENERAL_OUTPUT(gen_out), .HID_REPORTS(hid), .IRQ(irq));

   kdn_host_model host (
      .clk(clock), .restart(restart), .pins(gen_out), .hid(hid),
      .rst_n(rst_n), .pin_seen(pin_seen), .pin_len(pin_len),
      .hid_seen(hid_seen), .hid_len(hid_len), .falls(falls));

   task automatic complete_run;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %0h want %0h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      check(rdata, exp);
   endtask

   // Strobe held n cycles gives n detections
   task automatic detect(input int n);
      @(posedge clock);
      strobe <= 1'b1;
      tick(n);
      strobe <= 1'b0;
   endtask

   // Bounded wait for the partner to see more falling outputs
   task automatic wait_fall(input int more);
      nf = nf + more[7:0];
      for (int i = 0; i < 300 && falls !== nf; i++)
         @(posedge clock);
      if (falls !== nf) begin
         num_errors++;
         $display("[FAIL] %0t output never dropped", $time);
         complete_run();
      end
   endtask

   initial begin
      tick(12);
      for (int i = 0; i < 10; i++)
         reg_rd(offs[i], rv[i]);
      detect(1);
      tick(8);
      reg_rd(kdn_pkg::OFF_COUNT, 32'h0);
      check(hid, 48'h0);
      $display("test reset_and_no_model done");
      // Oversized model refused, then largest legal one loaded
      reg_wr(kdn_pkg::OFF_MODEL, 32'h0000_00FB);
      reg_rd(kdn_pkg::OFF_MODEL, 32'h0000_0000);
      reg_rd(kdn_pkg::OFF_IRQ_STAT, 32'h0000_0008);
      reg_wr(kdn_pkg::OFF_MODEL, 32'h0000_00FA);
      reg_rd(kdn_pkg::OFF_MODEL, 32'h0000_02FA);
      $display("test model done");
      // Counter and default HID bit, with back-to-back detections
      detect(3);
      wait_fall(1);
      check(hid_len, HOLD + 2);
      check(hid_seen, 48'h1);
      reg_rd(kdn_pkg::OFF_COUNT, 32'h3);
      reg_wr(kdn_pkg::OFF_COUNT, 32'h0);
      detect(1);
      wait_fall(1);
      check(hid_len, HOLD);
      reg_rd(kdn_pkg::OFF_COUNT, 32'h1);
      reg_wr(kdn_pkg::OFF_CTRL, 32'h4);
      detect(1);
      wait_fall(1);
      reg_rd(kdn_pkg::OFF_COUNT, 32'h1);
      $display("test counter_hid done");
      // Pulse path: zero mask silent, then each pin alone and a pair
      reg_wr(kdn_pkg::OFF_CTRL, 32'h3);
      reg_wr(kdn_pkg::OFF_PIN_MASK, 32'h0);
      reg_wr(kdn_pkg::OFF_PERIOD, 32'h2);
      detect(1);
      tick(20);
      check(falls, nf);
      for (int i = 0; i < 5; i++) begin
         reg_wr(kdn_pkg::OFF_PIN_MASK, (i < 4) ? (32'h1 << i) : 32'hA);
         detect(1);
         wait_fall(1);
         check(pin_seen, (i < 4) ? (48'h1 << i) : 48'hA);
         check(pin_len, 2 * TICK);
      end
      reg_wr(kdn_pkg::OFF_PERIOD, 32'h3);
      detect(1);
      tick(3);
      detect(1);
      wait_fall(1);
      check(pin_len, 5 + 3 * TICK);
      $display("test pulse done");
      // Remap to consumer byte 0 bit 1 under map table 2, source 0
      reg_wr(kdn_pkg::OFF_CTRL, 32'h4);
      reg_wr(kdn_pkg::OFF_HID_MAP, 32'h0000_020A);
      reg_wr(kdn_pkg::OFF_HID_MAP, 32'h0000_030A);
      reg_wr(kdn_pkg::OFF_HID_MAP, 32'h0000_0221);
      reg_rd(kdn_pkg::OFF_HID_MAP, 32'h0000_020A);
      // Model reject from earlier is still sticky beside both rejects
      reg_rd(kdn_pkg::OFF_IRQ_STAT, 32'h0000_000F);
      detect(1);
      wait_fall(1);
      check(hid_seen, 48'h0000_0002_0000);
      $display("test remap done");
      // Interrupt raised, masked and cleared
      reg_wr(kdn_pkg::OFF_CTRL, 32'h2);
      reg_wr(kdn_pkg::OFF_IRQ_STAT, 32'hF);
      reg_wr(kdn_pkg::OFF_IRQ_MASK, 32'h1);
      detect(1);
      tick(3);
      check(irq, 1'b1);
      reg_wr(kdn_pkg::OFF_IRQ_STAT, 32'h1);
      tick(2);
      check(irq, 1'b0);
      reg_wr(kdn_pkg::OFF_IRQ_MASK, 32'h0);
      detect(1);
      tick(3);
      check(irq, 1'b0);
      reg_rd(kdn_pkg::OFF_IRQ_STAT, 32'h1);
      $display("test irq done");
      // Boot data sets enables, pins, period and a telephony bit
      @(posedge clock);
      boot_cfg <= '{enables: 3'h5, pin_mask: 4'h5, period: 16'h0001,
                    map: '{report: 2'h3, byte_sel: 1'b1, bit_sel: 3'h5},
                    model_kb: 9'h0FA};
      boot_valid <= 1'b1;
      @(posedge clock);
      boot_valid <= 1'b0;
      reg_rd(kdn_pkg::OFF_PERIOD, 32'h1);
      detect(1);
      reg_rd(kdn_pkg::OFF_STATE, 32'h3);
      wait_fall(2);
      check(pin_seen, 48'h5);
      check(pin_len, TICK);
      check(hid_seen, 48'h2000_0000_0000);
      $display("test boot done");
      // Restart through the reset input brings back reset values
      @(posedge clock);
      restart <= 1'b1;
      @(posedge clock);
      restart <= 1'b0;
      tick(12);
      reg_rd(kdn_pkg::OFF_CTRL, rv[0]);
      reg_rd(kdn_pkg::OFF_COUNT, 32'h0);
      $display("test restart done");
      complete_run();
   end

   // Watchdog against a hang anywhere above
   initial begin
      tick(20000);
      num_errors++;
      $display("[FAIL] %0t run too long", $time);
      complete_run();
   end
endmodule
